// ==== dv/flash_device_model.sv ====
// Behavioural page-write flash device on the host pins
`timescale 1ns/1ps
`default_nettype none
module flash_device_model #(
	parameter int          PWR_NS   = 100,
	parameter int          WIN_NS   = 1000,
	parameter int          PROG_NS  = 20000,
	parameter int          ERASE_NS = 30000,
	parameter logic [15:0] MAKER_ID = 16'h1234, // Arbitrary value
	parameter logic [15:0] PART_ID  = 16'h5678  // Arbitrary value
) (
	input  wire logic        chip_select_n,
	input  wire logic        output_gate_n,
	input  wire logic        write_strobe_n,
	input  wire logic        id_override_line,
	input  wire logic [15:0] flash_addr,
	input  wire logic [15:0] flash_dq_o,
	output wire logic [15:0] flash_dq_i
);
	logic [15:0] mem [int];
	logic [15:0] buf_q [128];
	logic [15:0] val = 16'h0;
	logic [15:0] la, last_a;
	logic [8:0]  page;
	logic [2:0]  st = 3'h0;
	logic        prot = 1'b1;
	logic        arm = 1'b0, loading = 1'b0, busy = 1'b0, prog = 1'b0, id_mode = 1'b0;
	logic        tog = 1'b0;
	time         t_fall, t_last, t_end;
	wire         wr_n = chip_select_n | write_strobe_n | ~output_gate_n;
	wire         rd_n = chip_select_n | output_gate_n;
	// Released bus shows the inverse of the last word
	assign flash_dq_i = rd_n ? ~val : val;

	function automatic logic [15:0] rd(input logic [15:0] a);
		rd = mem.exists(a) ? mem[a] : 16'hffff;
	endfunction : rd
	function automatic logic fits(input logic [2:0] s, input logic [15:0] a, input logic [7:0] c);
		fits = (s % 3 == 1) ? a == 16'h2aaa && c == 8'h55 : a == 16'h5555 && (s % 3 == 2 || c == 8'haa);
	endfunction : fits

	task automatic load(input logic [15:0] a, input logic [15:0] d);
		if (!loading) begin
			page = a[15:7];
			foreach (buf_q[i]) buf_q[i] = 16'hffff;
		end
		if (a[15:7] != page) return;
		buf_q[a[6:0]] = d;
		loading = 1'b1;
		arm = 1'b0;
		last_a = a;
		t_last = $time;
	endtask : load

	task automatic take(input logic [15:0] a, input logic [15:0] d);
		logic [7:0] c;
		c = d[7:0];
		if (busy || $time < PWR_NS) return;
		if (loading || arm) begin
			load(a, d);
			return;
		end
		if (!fits(st, a, c)) st = 3'h0;
		if (!fits(st, a, c)) begin
			if (!prot) load(a, d);
			return;
		end
		st++;
		if (st == 3'h3) begin
			prot = prot || c == 8'ha0;
			arm = c == 8'ha0;
			if (c == 8'h90) id_mode = 1'b1;
			if (c == 8'hf0) id_mode = 1'b0;
			if (c != 8'h80) st = 3'h0;
		end else if (st == 3'h6) begin
			st = 3'h0;
			if (c == 8'h20) prot = 1'b0;
			if (c == 8'h60) id_mode = 1'b1;
			if (c == 8'h10) begin
				mem.delete();
				busy = 1'b1;
				prog = 1'b0;
				last_a = 16'h5555;
				t_end = $time + ERASE_NS;
			end
		end
	endtask : take

	always @(negedge wr_n) begin
		la = flash_addr;
		t_fall = $time;
	end
	always @(posedge wr_n) if ($time - t_fall >= 15) take(la, flash_dq_o);

	always #5 begin
		if (loading && $time - t_last >= WIN_NS) begin
			loading = 1'b0;
			busy = 1'b1;
			prog = 1'b1;
			t_end = $time + PROG_NS;
		end else if (busy && $time >= t_end) begin
			if (prog) foreach (buf_q[i]) mem[{page, i[6:0]}] = buf_q[i];
			busy = 1'b0;
		end
	end

	always @(negedge rd_n) begin
		if (id_mode || id_override_line)
			val = flash_addr == 16'h0 ? MAKER_ID : flash_addr == 16'h1 ? PART_ID : rd(flash_addr);
		else if (busy) begin
			tog = ~tog;
			val = (prog && flash_addr == last_a) ? buf_q[last_a[6:0]] ^ 16'h8080 : rd(flash_addr);
			val[6] = tog;
			val[14] = tog;
		end else
			val = rd(flash_addr);
	end
endmodule : flash_device_model
`default_nettype wire

// ==== dv/flash_host_properties.sv ====
// Pin-level checker for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module flash_host_properties (
	input wire logic                              ref_clk,
	input wire logic                              rst,
	input wire logic                              chip_select_n,
	input wire logic                              output_gate_n,
	input wire logic                              write_strobe_n,
	input wire logic                              id_override_line,
	input wire logic [flash_host_pkg::FA_W-1:0]   flash_addr,
	input wire logic [flash_host_pkg::FD_W-1:0]   flash_dq_o,
	input wire logic                              flash_dq_oe_n
);
	import flash_host_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_write_no_gate: assert property (
		!write_strobe_n |-> output_gate_n && !chip_select_n) else $error("strobe without select");
	a_read_dq_free: assert property (
		!output_gate_n |-> flash_dq_oe_n && !chip_select_n) else $error("gate low while driving");
	a_strobe_width: assert property (
		$fell(write_strobe_n) |-> !write_strobe_n [*3]) else $error("strobe pulse too short");
	a_data_hold: assert property (
		$rose(write_strobe_n) |-> !flash_dq_oe_n && $stable(flash_dq_o)) else $error("data not held");
	a_strobe_first: assert property (
		$rose(write_strobe_n) |-> !chip_select_n ##1 chip_select_n) else $error("select order");
	a_addr_steady: assert property (
		!chip_select_n && !$past(chip_select_n) |-> $stable(flash_addr)) else $error("address moved");
	a_hv_no_write: assert property (
		id_override_line |-> write_strobe_n) else $error("write under id voltage");
	a_select_gap: assert property (
		$rose(chip_select_n) |=> chip_select_n) else $error("select gap too short");
endmodule : flash_host_properties
bind flash_host flash_host_properties props (.ref_clk(ref_clk), .rst(rst),
	.chip_select_n(chip_select_n), .output_gate_n(output_gate_n),
	.write_strobe_n(write_strobe_n), .id_override_line(id_override_line),
	.flash_addr(flash_addr), .flash_dq_o(flash_dq_o), .flash_dq_oe_n(flash_dq_oe_n));
`default_nettype wire

// ==== dv/flash_host_test.sv ====
// Self-checking bench: flash host against a behavioural flash device
`timescale 1ns/1ps
`default_nettype none
module flash_host_test;
	import flash_host_pkg::*;
	localparam logic [15:0] MAKER = 16'h1234; // Arbitrary value
	localparam logic [15:0] PART  = 16'h5678; // Arbitrary value
	logic              ref_clk = 1'b0;
	logic              rst = 1'b1;
	logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [APB_AW-1:0] paddr = 8'h0;
	logic [31:0]       pwdata = 32'h0;
	logic [31:0]       rdv;
	logic              errv;
	int                checks = 0;
	int                n_errors = 0;
	wire logic [31:0]  prdata;
	wire logic         pready, pslverr, chip_select_n, output_gate_n, write_strobe_n;
	wire logic         id_override_line, flash_dq_oe_n;
	wire logic [15:0]  flash_addr, flash_dq_o, flash_dq_i;

	flash_host #(.POWERUP_CYCLES(20), .LOAD_WINDOW_CYCLES(100)) DUT (.ref_clk(ref_clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .chip_select_n(chip_select_n),
		.output_gate_n(output_gate_n), .write_strobe_n(write_strobe_n),
		.id_override_line(id_override_line), .flash_addr(flash_addr), .flash_dq_o(flash_dq_o),
		.flash_dq_oe_n(flash_dq_oe_n), .flash_dq_i(flash_dq_i));
	flash_device_model #(.MAKER_ID(MAKER), .PART_ID(PART)) flash (.chip_select_n(chip_select_n),
		.output_gate_n(output_gate_n), .write_strobe_n(write_strobe_n),
		.id_override_line(id_override_line), .flash_addr(flash_addr), .flash_dq_o(flash_dq_o),
		.flash_dq_i(flash_dq_i));

	always #2.5 ref_clk = ~ref_clk;

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic tally_and_finish;
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish
	task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
		if (n >= 16) begin
			n_errors++;
			tally_and_finish();
		end
	endtask : apb
	task automatic wait_status(input logic [1:0] want);
		int n;
		n = 0;
		do begin
			apb(1'b0, REG_STATUS, 32'h0);
			n++;
		end while (rdv[1:0] !== want && n < 20000);
		if (rdv[1:0] !== want) begin
			n_errors++;
			tally_and_finish();
		end
	endtask : wait_status
	task automatic cmd(input op_t op, input logic [15:0] a, input logic [15:0] d);
		apb(1'b1, REG_ADDR, {16'h0, a});
		apb(1'b1, REG_WDATA, {16'h0, d});
		apb(1'b1, REG_CMD, {29'h0, op});
	endtask : cmd
	task automatic rdw(input logic [15:0] a);
		cmd(OP_READ, a, 16'h0);
		wait_status(2'b00);
		apb(1'b0, REG_RDATA, 32'h0);
	endtask : rdw

	task automatic s_reset;
		apb(1'b0, REG_STATUS, 32'h0);
		chk("status", rdv, 32'h9);
		apb(1'b1, REG_CMD, {29'h0, OP_READ});
		apb(1'b0, REG_STATUS, 32'h0);
		chk("status", rdv, 32'hd);
		apb(1'b0, 8'h20, 32'h0);
		chk("slverr", {31'h0, errv}, 32'h1);
		wait_status(2'b00);
	endtask : s_reset
	task automatic s_protected;
		cmd(OP_LOAD, 16'h0105, 16'h1234);
		wait_status(2'b00);
		rdw(16'h0105);
		chk("word", rdv, 32'hffff);
		cmd(OP_LOAD_PROT, 16'h0183, 16'habcd);
		wait_status(2'b10);
		cmd(OP_LOAD, 16'h0180, 16'h5a5a);
		wait_status(2'b10);
		cmd(OP_LOAD, 16'h0280, 16'h0001);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("err", {31'h0, rdv[2]}, 32'h1);
		wait_status(2'b00);
		apb(1'b0, REG_RDATA, 32'h0);
		chk("poll", rdv, 32'h5a5a);
		rdw(16'h0181);
		chk("word", rdv, 32'hffff);
		rdw(16'h0183);
		chk("word", rdv, 32'habcd);
	endtask : s_protected
	task automatic s_unprotect_erase;
		cmd(OP_PROT_OFF, 16'h0, 16'h0);
		wait_status(2'b00);
		cmd(OP_LOAD, 16'h0200, 16'h0077);
		wait_status(2'b00);
		rdw(16'h0200);
		chk("word", rdv, 32'h0077);
		cmd(OP_ERASE, 16'h0, 16'h0);
		wait_status(2'b00);
		rdw(16'h0200);
		chk("word", rdv, 32'hffff);
	endtask : s_unprotect_erase
	task automatic s_ident(input op_t op);
		cmd(op, 16'h0, 16'h0);
		wait_status(2'b00);
		rdw(16'h0000);
		chk("maker", rdv, {16'h0, MAKER});
		rdw(16'h0001);
		chk("part", rdv, {16'h0, PART});
		cmd(OP_ID_EXIT, 16'h0, 16'h0);
		wait_status(2'b00);
		rdw(16'h0000);
		chk("word", rdv, 32'hffff);
	endtask : s_ident
	task automatic s_hv_ident;
		apb(1'b1, REG_CTRL, 32'h1);
		chk("override", {31'h0, id_override_line}, 32'h1);
		rdw(16'h0001);
		chk("part", rdv, {16'h0, PART});
		cmd(OP_LOAD, 16'h0300, 16'h0);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("status", rdv, 32'h14);
		apb(1'b1, REG_CTRL, 32'h0);
	endtask : s_hv_ident

	initial begin
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		s_reset();
		s_protected();
		s_unprotect_erase();
		s_ident(OP_ID_ENTER);
		s_ident(OP_ID_ENTER6);
		s_hv_ident();
		tally_and_finish();
	end
endmodule : flash_host_test
`default_nettype wire

// ==== src/flash_cycle_if.sv ====
// One flash bus cycle request and its answer, between sequencer and pin driver
`timescale 1ns/1ps
`default_nettype none
interface flash_cycle_if;
	import flash_host_pkg::*;
	logic            req;
	logic            wr;
	logic [FA_W-1:0] addr;
	logic [FD_W-1:0] wdata;
	logic            done;
	logic [FD_W-1:0] rdata;
	modport master (output req, output wr, output addr, output wdata, input done, input rdata);
	modport slave  (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface : flash_cycle_if
`default_nettype wire

// ==== src/flash_host.sv ====
// Host controller: APB registers, command sequencer and page load pacing for the flash
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module flash_host #(
	parameter int POWERUP_CYCLES     = flash_host_pkg::POWERUP_CYC,
	parameter int LOAD_WINDOW_CYCLES = flash_host_pkg::LOAD_WINDOW_CYC
) (
	input  wire logic                            ref_clk,
	input  wire logic                            rst,
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [flash_host_pkg::APB_AW-1:0] paddr,
	input  wire logic [31:0]                     pwdata,
	output var  logic [31:0]                     prdata,
	output var  logic                            pready,
	output var  logic                            pslverr,
	output var  logic                            chip_select_n,
	output var  logic                            output_gate_n,
	output var  logic                            write_strobe_n,
	output var  logic                            id_override_line,
	output var  logic [flash_host_pkg::FA_W-1:0]   flash_addr,
	output var  logic [flash_host_pkg::FD_W-1:0]   flash_dq_o,
	output var  logic                            flash_dq_oe_n,
	input  wire logic [flash_host_pkg::FD_W-1:0]   flash_dq_i
);
	import flash_host_pkg::*;

	typedef enum logic [2:0] {
		S_POWERUP = 3'h0,
		S_IDLE    = 3'h1,
		S_SEQ     = 3'h2,
		S_WORD    = 3'h3,
		S_WINDOW  = 3'h4,
		S_PAUSE   = 3'h5,
		S_POLL    = 3'h6
	} host_state_t;

	localparam logic [CNT_W-1:0] PWRUP_LAST = CNT_W'(POWERUP_CYCLES - 1);
	localparam logic [CNT_W-1:0] WIN_OPEN   = CNT_W'(LOAD_WINDOW_CYCLES);
	localparam logic [CNT_W-1:0] WIN_POLL   = CNT_W'(LOAD_WINDOW_CYCLES + CMD_PAUSE_CYC);
	localparam logic [CNT_W-1:0] PAUSE_LAST = CNT_W'(CMD_PAUSE_CYC - 1);

	flash_cycle_if cyc ();

	host_state_t       state_q;
	op_t               op_q;
	logic [2:0]        idx_q;
	logic [CNT_W-1:0]  cnt_q;
	logic [FA_W-1:0]   addr_q;
	logic [FD_W-1:0]   wdata_q;
	logic [FA_W-1:0]   word_addr_q;
	logic [FD_W-1:0]   word_data_q;
	logic [PAGE_W-1:0] page_q;
	logic [FA_W-1:0]   poll_addr_q;
	logic [FD_W-1:0]   prev_q;
	logic              have_prev_q;
	logic [FD_W-1:0]   rdata_q;
	logic              err_q;

	// APB decode
	wire        apb_access = psel && penable && pready;
	wire        apb_wr     = apb_access && pwrite;
	wire        cmd_wr     = apb_wr && (paddr == REG_CMD);
	wire op_t   op_new     = op_t'(pwdata[OP_W-1:0]);
	wire        same_page  = (addr_q[FA_W-1:PAGE_LSB] == page_q);
	wire        hv_block   = id_override_line && (op_new != OP_READ);
	wire        take_idle  = (state_q == S_IDLE) && !hv_block;
	wire        take_win   = (state_q == S_WINDOW) && (op_new == OP_LOAD) && same_page
		&& (cnt_q < WIN_OPEN);
	wire        accept     = cmd_wr && (take_idle || take_win);
	wire        has_prefix = (op_new != OP_READ) && (op_new != OP_LOAD);
	wire        mapped     = (paddr == REG_CMD) || (paddr == REG_ADDR) || (paddr == REG_WDATA)
		|| (paddr == REG_RDATA) || (paddr == REG_STATUS) || (paddr == REG_CTRL);
	wire        busy       = (state_q != S_IDLE) && (state_q != S_WINDOW);
	wire [31:0] status_word = {27'h0, id_override_line, state_q == S_POWERUP, err_q,
		state_q == S_WINDOW, busy};
	wire [31:0] rd_mux     = (paddr == REG_ADDR)   ? {16'h0, addr_q} :
		(paddr == REG_WDATA)  ? {16'h0, wdata_q} :
		(paddr == REG_RDATA)  ? {16'h0, rdata_q} :
		(paddr == REG_STATUS) ? status_word :
		(paddr == REG_CTRL)   ? {31'h0, id_override_line} : 32'h0;

	// Sequencer to pin cycle request
	wire seq_last   = (idx_q == seq_len(op_q) - 3'h1);
	wire toggle_eq  = (prev_q[TOGGLE_LO] == cyc.rdata[TOGGLE_LO])
		&& (prev_q[TOGGLE_HI] == cyc.rdata[TOGGLE_HI]);
	assign cyc.req   = (state_q == S_SEQ) || (state_q == S_WORD) || (state_q == S_POLL);
	assign cyc.wr    = (state_q == S_SEQ) || ((state_q == S_WORD) && (op_q != OP_READ));
	assign cyc.addr  = (state_q == S_SEQ) ? seq_addr(idx_q) :
		(state_q == S_WORD) ? word_addr_q : poll_addr_q;
	assign cyc.wdata = (state_q == S_SEQ) ? seq_data(op_q, idx_q) : word_data_q;

	flash_pin_cycle u_pins (
		.ref_clk        (ref_clk),
		.rst            (rst),
		.cyc            (cyc.slave),
		.chip_select_n  (chip_select_n),
		.output_gate_n  (output_gate_n),
		.write_strobe_n (write_strobe_n),
		.flash_addr     (flash_addr),
		.flash_dq_o     (flash_dq_o),
		.flash_dq_oe_n  (flash_dq_oe_n),
		.flash_dq_i     (flash_dq_i)
	);

	// APB slave: answers in the first access cycle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata  <= (psel && !penable) ? rd_mux : 32'h0;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			addr_q           <= '0;
			wdata_q          <= '0;
			id_override_line <= 1'b0;
		end else if (apb_wr) begin
			if (paddr == REG_ADDR) addr_q <= pwdata[FA_W-1:0];
			if (paddr == REG_WDATA) wdata_q <= pwdata[FD_W-1:0];
			// Idle only: a raised id line during a window or poll would corrupt polling
			if (paddr == REG_CTRL && state_q == S_IDLE) id_override_line <= pwdata[CTRL_ID_HV];
		end
	end

	// Refused command is sticky until the next accepted one
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			err_q <= 1'b0;
		end else if (cmd_wr) begin
			err_q <= !accept;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q     <= S_POWERUP;
			op_q        <= OP_READ;
			idx_q       <= '0;
			cnt_q       <= '0;
			word_addr_q <= '0;
			word_data_q <= '0;
			page_q      <= '0;
			poll_addr_q <= '0;
			prev_q      <= '0;
			have_prev_q <= 1'b0;
			rdata_q     <= '0;
		end else if (accept) begin
			op_q        <= op_new;
			idx_q       <= '0;
			word_addr_q <= addr_q;
			word_data_q <= wdata_q;
			state_q     <= has_prefix ? S_SEQ : S_WORD;
		end else begin
			case (state_q)
				S_POWERUP: begin
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q == PWRUP_LAST) state_q <= S_IDLE;
				end
				S_SEQ: begin
					if (cyc.done && !seq_last) idx_q <= idx_q + 3'h1;
					if (cyc.done && seq_last) begin
						cnt_q       <= '0;
						have_prev_q <= 1'b0;
						poll_addr_q <= CMD_ADDR_A;
						case (op_q)
							OP_LOAD_PROT: state_q <= S_WORD;
							OP_ERASE:     state_q <= S_POLL;
							default:      state_q <= S_PAUSE;
						endcase
					end
				end
				S_WORD: begin
					if (cyc.done && op_q == OP_READ) begin
						rdata_q <= cyc.rdata;
						state_q <= S_IDLE;
					end else if (cyc.done) begin
						page_q      <= word_addr_q[FA_W-1:PAGE_LSB];
						poll_addr_q <= word_addr_q;
						cnt_q       <= '0;
						state_q     <= S_WINDOW;
					end
				end
				S_WINDOW: begin
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q == WIN_POLL) begin
						have_prev_q <= 1'b0;
						state_q     <= S_POLL;
					end
				end
				S_PAUSE: begin
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q == PAUSE_LAST) state_q <= S_IDLE;
				end
				S_POLL: begin
					if (cyc.done) begin
						prev_q      <= cyc.rdata;
						have_prev_q <= 1'b1;
						if (have_prev_q && toggle_eq) begin
							rdata_q <= cyc.rdata;
							state_q <= S_IDLE;
						end
					end
				end
				S_IDLE:  cnt_q <= '0;
				default: state_q <= S_IDLE;
			endcase
		end
	end

endmodule : flash_host
`default_nettype wire

// ==== src/flash_host_pkg.sv ====
// Constants, types and command tables for the page-write flash host controller
package flash_host_pkg;

	// Clock and timing
	localparam int CLK_PERIOD_PS   = 5000;
	localparam int WE_LOW_NS       = 15;
	localparam int WE_LOW_CYC      = (WE_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int READ_ACCESS_NS  = 120;
	localparam int READ_ACCESS_CYC = (READ_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int LOAD_WINDOW_US  = 200;
	localparam int LOAD_WINDOW_CYC = LOAD_WINDOW_US * (1000000 / CLK_PERIOD_PS);
	localparam int CMD_PAUSE_US    = 10;
	localparam int CMD_PAUSE_CYC   = (CMD_PAUSE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int POWERUP_MS      = 5;
	localparam int POWERUP_CYC     = POWERUP_MS * (1000000000 / CLK_PERIOD_PS);
	localparam int CNT_W           = 21;
	localparam int PIN_CNT_W       = 8;

	// Flash word geometry
	localparam int FA_W      = 16;
	localparam int FD_W      = 16;
	localparam int PAGE_LSB  = 7;
	localparam int PAGE_W    = FA_W - PAGE_LSB;
	localparam int TOGGLE_LO = 6;
	localparam int TOGGLE_HI = 14;

	// Command addresses and words
	localparam logic [FA_W-1:0] CMD_ADDR_A    = 16'h5555;
	localparam logic [FA_W-1:0] CMD_ADDR_B    = 16'h2aaa;
	localparam logic [FD_W-1:0] UNLOCK_A      = 16'haaaa;
	localparam logic [FD_W-1:0] UNLOCK_B      = 16'h5555;
	localparam logic [FD_W-1:0] CODE_PROT_ON  = 16'ha0a0;
	localparam logic [FD_W-1:0] CODE_SETUP    = 16'h8080;
	localparam logic [FD_W-1:0] CODE_PROT_OFF = 16'h2020;
	localparam logic [FD_W-1:0] CODE_ERASE    = 16'h1010;
	localparam logic [FD_W-1:0] CODE_ID3      = 16'h9090;
	localparam logic [FD_W-1:0] CODE_ID6      = 16'h6060;
	localparam logic [FD_W-1:0] CODE_ID_EXIT  = 16'hf0f0;
	localparam logic [2:0]      SEQ_SHORT     = 3'h3;
	localparam logic [2:0]      SEQ_LONG      = 3'h6;

	// APB register map
	localparam int              APB_AW     = 8;
	localparam logic [APB_AW-1:0] REG_CMD    = 8'h00;
	localparam logic [APB_AW-1:0] REG_ADDR   = 8'h04;
	localparam logic [APB_AW-1:0] REG_WDATA  = 8'h08;
	localparam logic [APB_AW-1:0] REG_RDATA  = 8'h0c;
	localparam logic [APB_AW-1:0] REG_STATUS = 8'h10;
	localparam logic [APB_AW-1:0] REG_CTRL   = 8'h14;
	localparam int ST_BUSY      = 0;
	localparam int ST_PAGE_OPEN = 1;
	localparam int ST_ERR       = 2;
	localparam int ST_POWERUP   = 3;
	localparam int ST_ID_HV     = 4;
	localparam int CTRL_ID_HV   = 0;
	localparam int OP_W         = 3;

	typedef enum logic [OP_W-1:0] {
		OP_READ      = 3'h0,
		OP_LOAD      = 3'h1,
		OP_LOAD_PROT = 3'h2,
		OP_PROT_OFF  = 3'h3,
		OP_ERASE     = 3'h4,
		OP_ID_ENTER  = 3'h5,
		OP_ID_ENTER6 = 3'h6,
		OP_ID_EXIT   = 3'h7
	} op_t;

	function automatic logic [2:0] seq_len(input op_t op);
		case (op)
			OP_PROT_OFF, OP_ERASE, OP_ID_ENTER6: seq_len = SEQ_LONG;
			default:                             seq_len = SEQ_SHORT;
		endcase
	endfunction : seq_len

	function automatic logic [FA_W-1:0] seq_addr(input logic [2:0] idx);
		seq_addr = (idx == 3'h1 || idx == 3'h4) ? CMD_ADDR_B : CMD_ADDR_A;
	endfunction : seq_addr

	function automatic logic [FD_W-1:0] seq_data(input op_t op, input logic [2:0] idx);
		case (idx)
			3'h0, 3'h3: seq_data = UNLOCK_A;
			3'h1, 3'h4: seq_data = UNLOCK_B;
			3'h2: begin
				case (op)
					OP_LOAD_PROT: seq_data = CODE_PROT_ON;
					OP_ID_ENTER:  seq_data = CODE_ID3;
					OP_ID_EXIT:   seq_data = CODE_ID_EXIT;
					default:      seq_data = CODE_SETUP;
				endcase
			end
			default: begin
				case (op)
					OP_PROT_OFF: seq_data = CODE_PROT_OFF;
					OP_ERASE:    seq_data = CODE_ERASE;
					default:     seq_data = CODE_ID6;
				endcase
			end
		endcase
	endfunction : seq_data

endpackage : flash_host_pkg

// ==== src/flash_pin_cycle.sv ====
// Drives one read or write cycle on the flash pins
`timescale 1ns/1ps
`default_nettype none
module flash_pin_cycle (
	input  wire logic                          ref_clk,
	input  wire logic                          rst,
	flash_cycle_if.slave                       cyc,
	output var  logic                          chip_select_n,
	output var  logic                          output_gate_n,
	output var  logic                          write_strobe_n,
	output var  logic [flash_host_pkg::FA_W-1:0] flash_addr,
	output var  logic [flash_host_pkg::FD_W-1:0] flash_dq_o,
	output var  logic                          flash_dq_oe_n,
	input  wire logic [flash_host_pkg::FD_W-1:0] flash_dq_i
);
	import flash_host_pkg::*;

	typedef enum logic [2:0] {
		C_IDLE    = 3'h0,
		C_SETUP   = 3'h1,
		C_STROBE  = 3'h2,
		C_RELEASE = 3'h3,
		C_DONE    = 3'h4
	} cyc_state_t;

	localparam logic [PIN_CNT_W-1:0] WE_LAST = PIN_CNT_W'(WE_LOW_CYC - 1);
	localparam logic [PIN_CNT_W-1:0] RD_LAST = PIN_CNT_W'(READ_ACCESS_CYC - 1);

	cyc_state_t           state_q;
	logic [PIN_CNT_W-1:0] cnt_q;
	logic                 wr_q;
	logic                 done_q;
	logic [FD_W-1:0]      rdata_q;
	wire  [PIN_CNT_W-1:0] strobe_last = wr_q ? WE_LAST : RD_LAST;
	wire                  strobe_end  = (state_q == C_STROBE) && (cnt_q == strobe_last);

	assign cyc.done  = done_q;
	assign cyc.rdata = rdata_q;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= C_IDLE;
			cnt_q   <= '0;
			done_q  <= 1'b0;
		end else begin
			done_q <= (state_q == C_RELEASE);
			cnt_q  <= (state_q == C_STROBE) ? cnt_q + 1'b1 : '0;
			case (state_q)
				C_IDLE:    state_q <= cyc.req ? C_SETUP : C_IDLE;
				C_SETUP:   state_q <= C_STROBE;
				C_STROBE:  state_q <= strobe_end ? C_RELEASE : C_STROBE;
				C_RELEASE: state_q <= C_DONE;
				C_DONE:    state_q <= C_IDLE;
				default:   state_q <= C_IDLE;
			endcase
		end
	end

	// Select falls first, so the strobe edge latches the address
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			chip_select_n  <= 1'b1;
			output_gate_n  <= 1'b1;
			write_strobe_n <= 1'b1;
			flash_dq_oe_n  <= 1'b1;
			flash_addr     <= '0;
			flash_dq_o     <= '0;
			wr_q           <= 1'b0;
		end else if (state_q == C_IDLE && cyc.req) begin
			chip_select_n <= 1'b0;
			flash_addr    <= cyc.addr;
			flash_dq_o    <= cyc.wdata;
			flash_dq_oe_n <= ~cyc.wr;
			wr_q          <= cyc.wr;
		end else if (state_q == C_SETUP) begin
			write_strobe_n <= ~wr_q;
			output_gate_n  <= wr_q;
		end else if (strobe_end) begin
			write_strobe_n <= 1'b1;
			output_gate_n  <= 1'b1;
		end else if (state_q == C_RELEASE) begin
			chip_select_n <= 1'b1;
			flash_dq_oe_n <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdata_q <= '0;
		end else if (strobe_end && !wr_q) begin
			rdata_q <= flash_dq_i;
		end
	end

endmodule : flash_pin_cycle
`default_nettype wire
